// ---- hw/hsief_top.sv ----
// interrupt enable and frame index slice of a usb host, axi4-lite slave
// Overview of operation
// - async advance irq waits threshold boundary
// - system error irq raised without threshold
// - rollover irq raised immediately
// - port change irq raised immediately
// - transfer error irq waits threshold
// - transfer done irq waits threshold
// - enable bits 31..6 reserved, read zero
// - frame index steps every 125 us
// - index bits N..3 select list entry
// - list size picks N 12/11/10
// - start-of-frame number is bits 13..3
// - frame index writable only while halted
// - written index changes later frame numbers
//
// The AXI4-Lite register port was chosen for this implementation.
`include "hsief_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hsief_top
    import hsief_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire hsief_irq_t        event_i,         // one-cycle event pulses
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output var  logic              s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output var  logic              s_axi_wready_o,
    output var  logic [1:0]        s_axi_bresp_o,
    output var  logic              s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output var  logic              s_axi_arready_o,
    output var  logic [31:0]       s_axi_rdata_o,
    output var  logic [1:0]        s_axi_rresp_o,
    output var  logic              s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output var  logic              irq_o,           // level interrupt
    output var  logic [9:0]        frame_entry_o,   // periodic list entry
    output var  logic [10:0]       sof_frame_o,     // start-of-frame number
    output var  logic              run_o            // schedule running
);
    localparam int UFRAME_CYC = `HSIEF_UFRAME_CYC;
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic              aw_h_reg, aw_h_next;   // write address held
    logic              w_h_reg,  w_h_next;    // write data held
    logic [ADDR_W-1:0] awa_reg,  awa_next;
    logic [31:0]       wd_reg,   wd_next;
    logic [3:0]        ws_reg,   ws_next;
    logic              awr_reg,  awr_next;
    logic              wr_reg,   wr_next;
    logic              bv_reg,   bv_next;
    logic [1:0]        br_reg,   br_next;
    logic              arr_reg,  arr_next;
    logic              rv_reg,   rv_next;
    logic [31:0]       rd_reg,   rd_next;
    logic [1:0]        rr_reg,   rr_next;
    logic              run_reg,  run_next;    // run_control
    logic              hlt_reg,  hlt_next;    // halted_indicator
    logic [1:0]        fls_reg,  fls_next;    // list_size_select
    logic [7:0]        thr_reg,  thr_next;    // threshold, microframes
    logic [7:0]        tc_reg,   tc_next;     // threshold counter
    logic              arm_reg,  arm_next;    // threshold boundary passed
    hsief_irq_t        en_reg,   en_next;     // interrupt_enable
    hsief_irq_t        sts_reg,  sts_next;    // status flags
    logic [13:0]       fri_reg,  fri_next;    // frame_index
    logic [9:0]        ent_reg,  ent_next;
    logic              irq_reg,  irq_next;
    logic              tick;                  // microframe end
    logic              do_wr;
    logic [7:0]        wofs;
    logic [7:0]        rofs;
    logic              wr_hit;
    logic              ovr;                   // frame list rollover
    logic [13:0]       low_mask;
    hsief_irq_t        set_v, clr_v, pend;
    logic [5:0]        imm_m, thr_m;
    logic [31:0]       rmux;
    logic              rhit;

    // ---------------------------------------------------------------
    // microframe timer
    // ---------------------------------------------------------------
    hsief_uframe_timer #(
        .CYCLES (UFRAME_CYC)
    ) u_timer (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .run_i  (run_reg),
        .tick_o (tick)
    );

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    assign do_wr  = aw_h_reg & w_h_reg & ~bv_reg;
    assign wofs   = {awa_reg[7:2], 2'b00};
    assign rofs   = {s_axi_araddr_i[7:2], 2'b00};
    assign wr_hit = (wofs == `HSIEF_CMD_OFS) || (wofs == `HSIEF_STS_OFS) ||
                    (wofs == `HSIEF_EN_OFS)  || (wofs == `HSIEF_FRI_OFS);
    assign pend   = sts_reg & en_reg;
    assign imm_m  = 6'b01_1100;              // error, rollover, port change
    assign thr_m  = 6'b10_0011;              // advance, error, done

    // span of the wrapping index bits N..0
    always_comb begin
        case (fls_reg)
            2'b01:   low_mask = 14'h0fff;    // 512 entries, N=11
            2'b10:   low_mask = 14'h07ff;    // 256 entries, N=10
            default: low_mask = 14'h1fff;    // 1024 entries, N=12
        endcase
    end
    assign ovr = tick & run_reg & ((fri_reg & low_mask) == low_mask);

    // ---------------------------------------------------------------
    // axi4-lite channels
    // ---------------------------------------------------------------
    always_comb begin
        aw_h_next = aw_h_reg;
        w_h_next  = w_h_reg;
        awa_next  = awa_reg;
        wd_next   = wd_reg;
        ws_next   = ws_reg;
        bv_next   = bv_reg;
        br_next   = br_reg;
        rv_next   = rv_reg;
        rd_next   = rd_reg;
        rr_next   = rr_reg;
        // address and data taken in either order
        if (s_axi_awvalid_i && awr_reg) begin
            aw_h_next = 1'b1;
            awa_next  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wr_reg) begin
            w_h_next = 1'b1;
            wd_next  = s_axi_wdata_i;
            ws_next  = s_axi_wstrb_i;
        end
        // both held: commit and answer
        if (do_wr) begin
            aw_h_next = 1'b0;
            w_h_next  = 1'b0;
            bv_next   = 1'b1;
            br_next   = wr_hit ? HSIEF_OKAY : HSIEF_SLVERR;
        end else if (bv_reg && s_axi_bready_i) begin
            bv_next = 1'b0;
        end
        // read answered the cycle after the address
        if (s_axi_arvalid_i && arr_reg) begin
            rv_next = 1'b1;
            rd_next = rmux;
            rr_next = rhit ? HSIEF_OKAY : HSIEF_SLVERR;
        end else if (rv_reg && s_axi_rready_i) begin
            rv_next = 1'b0;
        end
        awr_next = ~aw_h_next & ~bv_next;
        wr_next  = ~w_h_next & ~bv_next;
        arr_next = ~rv_next;
    end

    // read mux, reserved bits read zero
    always_comb begin
        rhit = 1'b1;
        case (rofs)
            `HSIEF_CMD_OFS: rmux = {8'h00, thr_reg, 12'h000, fls_reg, 1'b0, run_reg};
            `HSIEF_STS_OFS: rmux = {19'h0_0000, hlt_reg, 6'h00, sts_reg};
            `HSIEF_EN_OFS:  rmux = {26'h000_0000, en_reg};
            `HSIEF_FRI_OFS: rmux = {18'h0_0000, fri_reg};
            default: begin
                rmux = 32'h0000_0000;
                rhit = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // control, enable, frame index
    // ---------------------------------------------------------------
    always_comb begin
        run_next = run_reg;
        fls_next = fls_reg;
        thr_next = thr_reg;
        en_next  = en_reg;
        fri_next = fri_reg;
        hlt_next = ~run_reg;                 // halts one cycle after stop
        if (do_wr && wofs == `HSIEF_CMD_OFS) begin
            if (ws_reg[0]) begin
                run_next = wd_reg[`HSIEF_CMD_RUN_BIT];
                fls_next = wd_reg[`HSIEF_CMD_FLS_LSB +: 2];
            end
            if (ws_reg[2]) begin
                thr_next = wd_reg[`HSIEF_CMD_THR_LSB +: 8];
            end
        end
        if (do_wr && wofs == `HSIEF_EN_OFS && ws_reg[0]) begin
            en_next = wd_reg[5:0];
        end
        // a word write while halted reloads the index
        if (do_wr && wofs == `HSIEF_FRI_OFS && hlt_reg && ws_reg == 4'hf) begin
            fri_next = wd_reg[13:0];
        end else if (tick && run_reg) begin
            fri_next = fri_reg + 14'h0001;
        end
    end

    // list entry from bits N..3, frame number from bits 13..3
    always_comb begin
        case (fls_next)
            2'b01:   ent_next = {1'b0, fri_next[11:3]};
            2'b10:   ent_next = {2'b00, fri_next[10:3]};
            default: ent_next = fri_next[12:3];
        endcase
    end

    // ---------------------------------------------------------------
    // status flags and interrupt
    // ---------------------------------------------------------------
    always_comb begin
        set_v = event_i;
        set_v.rollover_flag = event_i.rollover_flag | ovr;
        clr_v = 6'h00;
        if (do_wr && wofs == `HSIEF_STS_OFS && ws_reg[0]) begin
            clr_v = wd_reg[5:0];
        end
    end

    // sticky flags, write one clears, a set wins over a clear
    for (genvar g = 0; g < 6; g++) begin : g_flag
        assign sts_next[g] = set_v[g] | (sts_reg[g] & ~clr_v[g]);
    end

    // threshold boundary every thr_reg microframes
    always_comb begin
        tc_next  = tc_reg;
        arm_next = arm_reg;
        if (tick && run_reg) begin
            if (tc_reg + 8'h01 >= thr_reg) begin
                tc_next  = 8'h00;
                arm_next = |(pend & thr_m);
            end else begin
                tc_next = tc_reg + 8'h01;
            end
        end
        if (!(|(pend & thr_m))) begin
            arm_next = 1'b0;                 // acknowledged
        end
        irq_next = (|(pend & imm_m)) | arm_next;
    end

    // registers only
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            aw_h_reg <= 1'b0;
            w_h_reg  <= 1'b0;
            awa_reg  <= '0;
            wd_reg   <= 32'h0000_0000;
            ws_reg   <= 4'h0;
            awr_reg  <= 1'b0;
            wr_reg   <= 1'b0;
            bv_reg   <= 1'b0;
            br_reg   <= 2'h0;
            arr_reg  <= 1'b0;
            rv_reg   <= 1'b0;
            rd_reg   <= 32'h0000_0000;
            rr_reg   <= 2'h0;
            run_reg  <= 1'b0;
            hlt_reg  <= 1'b1;
            fls_reg  <= 2'h0;
            thr_reg  <= `HSIEF_THR_RST;
            tc_reg   <= 8'h00;
            arm_reg  <= 1'b0;
            en_reg   <= `HSIEF_EN_RST;
            sts_reg  <= 6'h00;
            fri_reg  <= `HSIEF_FRI_RST;
            ent_reg  <= 10'h000;
            irq_reg  <= 1'b0;
        end else begin
            aw_h_reg <= aw_h_next;
            w_h_reg  <= w_h_next;
            awa_reg  <= awa_next;
            wd_reg   <= wd_next;
            ws_reg   <= ws_next;
            awr_reg  <= awr_next;
            wr_reg   <= wr_next;
            bv_reg   <= bv_next;
            br_reg   <= br_next;
            arr_reg  <= arr_next;
            rv_reg   <= rv_next;
            rd_reg   <= rd_next;
            rr_reg   <= rr_next;
            run_reg  <= run_next;
            hlt_reg  <= hlt_next;
            fls_reg  <= fls_next;
            thr_reg  <= thr_next;
            tc_reg   <= tc_next;
            arm_reg  <= arm_next;
            en_reg   <= en_next;
            sts_reg  <= sts_next;
            fri_reg  <= fri_next;
            ent_reg  <= ent_next;
            irq_reg  <= irq_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign s_axi_awready_o = awr_reg;
    assign s_axi_wready_o  = wr_reg;
    assign s_axi_bvalid_o  = bv_reg;
    assign s_axi_bresp_o   = br_reg;
    assign s_axi_arready_o = arr_reg;
    assign s_axi_rvalid_o  = rv_reg;
    assign s_axi_rdata_o   = rd_reg;
    assign s_axi_rresp_o   = rr_reg;
    assign irq_o           = irq_reg;
    assign frame_entry_o   = ent_reg;
    assign sof_frame_o     = fri_reg[13:3];
    assign run_o           = run_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    property p_sys_err;
        sts_reg.se && en_reg.se |=> irq_o;
    endproperty
    a_sys_err: assert property (p_sys_err) else $error("system error irq missing");

    property p_roll;
        sts_reg.rollover_flag && en_reg.rollover_flag |=> irq_o;
    endproperty
    a_roll: assert property (p_roll) else $error("rollover irq missing");

    property p_port;
        sts_reg.pc && en_reg.pc |=> irq_o;
    endproperty
    a_port: assert property (p_port) else $error("port change irq missing");

    property p_thr_wait;
        !(|(pend & imm_m)) && !arm_reg && !(tick && run_reg) |=> !irq_o;
    endproperty
    a_thr_wait: assert property (p_thr_wait) else $error("threshold irq too early");

    property p_thr_fire;
        tick && run_reg && (tc_reg + 8'h01 >= thr_reg) && (|(pend & thr_m)) |=> arm_reg && irq_o;
    endproperty
    a_thr_fire: assert property (p_thr_fire) else $error("threshold irq missing");

    property p_en_rsvd;
        arr_reg && s_axi_arvalid_i && rofs == `HSIEF_EN_OFS |=> rd_reg[31:6] == 26'h000_0000;
    endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("enable reserved bits nonzero");

    property p_step;
        tick && run_reg && !do_wr |=> fri_reg == $past(fri_reg) + 14'h0001;
    endproperty
    a_step: assert property (p_step) else $error("frame index did not step");

    property p_entry;
        fls_reg == 2'b00 |-> ent_reg == fri_reg[12:3];
    endproperty
    a_entry: assert property (p_entry) else $error("list entry mismatch");

    property p_sof;
        do_wr && wofs == `HSIEF_FRI_OFS && hlt_reg && ws_reg == 4'hf |=> sof_frame_o == wd_reg[13:3];
    endproperty
    a_sof: assert property (p_sof) else $error("frame number mismatch");

    property p_locked;
        do_wr && wofs == `HSIEF_FRI_OFS && !hlt_reg && !tick |=> $stable(fri_reg);
    endproperty
    a_locked: assert property (p_locked) else $error("index written while running");

    property p_quiet;
        !(|pend) |=> !irq_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq without pair");
endmodule
`default_nettype wire

// ---- hw/hsief_defines.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef HSIEF_DEFINES_SVH
`define HSIEF_DEFINES_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define HSIEF_CMD_OFS     8'h00
`define HSIEF_STS_OFS     8'h04
`define HSIEF_EN_OFS      8'h08
`define HSIEF_FRI_OFS     8'h18
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define HSIEF_CMD_RUN_BIT 0
`define HSIEF_CMD_FLS_LSB 2
`define HSIEF_CMD_THR_LSB 16
`define HSIEF_STS_HLT_BIT 12
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define HSIEF_THR_RST     8'h08
`define HSIEF_FRI_RST     14'h0000
`define HSIEF_EN_RST      6'h00
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define HSIEF_CLK_NS      40
`define HSIEF_UFRAME_NS   125000
`define HSIEF_UFRAME_CYC  (`HSIEF_UFRAME_NS / `HSIEF_CLK_NS)
`endif

// ---- hw/hsief_pkg.sv ----
// types shared by the interrupt enable and frame index slice
package hsief_pkg;
    // six event flags, same layout for status and enable
    typedef struct packed {
        logic aa;   // async advance
        logic se;   // host system error
        logic rollover_flag;  // frame list rollover
        logic pc;   // port change
        logic err;  // transfer error
        logic done; // transfer complete
    } hsief_irq_t;
    // axi response codes
    typedef enum logic [1:0] {
        HSIEF_OKAY   = 2'h0,
        HSIEF_SLVERR = 2'h2
    } hsief_resp_t;
endpackage

// ---- hw/hsief_uframe_timer.sv ----
// microframe timer: one-cycle tick every microframe while running
`timescale 1ns/1ps
`default_nettype none
module hsief_uframe_timer #(
    parameter int CYCLES = 3125
) (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    output var  logic tick_o
);
    // ---------------------------------------------------------------
    // divider
    // ---------------------------------------------------------------
    logic [12:0] cnt_reg;  // cycles into the microframe
    logic [12:0] cnt_next;
    logic        tick_reg;
    logic        tick_next;

    // count while running, restart from zero when stopped
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!run_i) begin
            cnt_next = 13'h0000;
        end else if (cnt_reg == 13'(CYCLES - 1)) begin
            cnt_next  = 13'h0000;
            tick_next = 1'b1;    // end of microframe
        end else begin
            cnt_next = cnt_reg + 13'h0001;
        end
    end

    // registers only
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cnt_reg  <= 13'h0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule
`default_nettype wire

// ---- tb/hs_host_irq_enable_frame_index_tb.sv ----
// self-checking bench for the interrupt enable and frame index slice
`include "hsief_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hs_host_irq_enable_frame_index_tb
    import hsief_pkg::*;
;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic        mclk_i;       // core clock
    logic        rstn_i;       // synchronous reset, active low
    hsief_irq_t  ev;           // event pulses
    logic [7:0]  awaddr;       // write address
    logic [7:0]  araddr;       // read address
    logic [31:0] wdata;        // write data
    logic [3:0]  wstrb;        // write lanes
    logic        awvalid;      // write address valid
    logic        wvalid;       // write data valid
    logic        bready;       // response ready
    logic        arvalid;      // read address valid
    logic        rready;       // read data ready
    logic        awready;      // slave outputs below
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        irq;          // level interrupt
    logic        run;          // schedule running
    logic [9:0]  entry;        // periodic list entry
    logic [10:0] sof;          // start-of-frame number
    int          err_count;    // mismatches
    int          n_compared;   // comparisons
    int          cyc = 0;      // free cycle counter for timing checks
    hsief_top u_hsief_top (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .event_i(ev),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .irq_o(irq), .frame_entry_o(entry), .sof_frame_o(sof), .run_o(run)
    );
    // ---------------------------------------------------------------
    // clock and cycle count
    // ---------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
    end
    // ---------------------------------------------------------------
    // helper tasks
    // ---------------------------------------------------------------
    // verdict and end of run
    task automatic final_report;
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one comparison, reported at once on mismatch
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // axi write: address and data offered together, ready sampled at negedge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic ah, wh, bh, done;
        done = 1'b0;
        @(posedge mclk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge mclk_i);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid & bready;
            if (bh) r = bresp;
            @(posedge mclk_i);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // axi read: data taken at the negedge where rvalid and rready are high
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, done;
        done = 1'b0;
        @(posedge mclk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge mclk_i);
            ah = arvalid & arready;
            if (rvalid & rready) begin
                d = rdata;
                r = rresp;
                done = 1'b1;
            end
            @(posedge mclk_i);
            if (ah) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
    endtask
    // full-word write expecting an okay response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hf, r);
        check(32'(r), 32'(HSIEF_OKAY));
    endtask
    // read, compare masked data, expect okay
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(d & m, e);
        check(32'(r), 32'(HSIEF_OKAY));
    endtask
    // one-cycle event pulse on a single flag
    task automatic pulse(input int k);
        @(posedge mclk_i);
        ev <= hsief_irq_t'(6'h01 << k);
        @(posedge mclk_i);
        ev <= hsief_irq_t'(6'h00);
    endtask
    // interrupt level after n edges
    task automatic irq_chk(input int n, input logic e);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
        check({31'h0, irq}, {31'h0, e});
    endtask
    // poll frame index until it steps; return new value and cycle stamp
    task automatic sync(output logic [31:0] v, output int t);
        logic [31:0] v0, x;
        logic [1:0]  r;
        axi_rd(`HSIEF_FRI_OFS, v0, r);
        x = v0;
        while (x === v0) axi_rd(`HSIEF_FRI_OFS, x, r);
        v = x;
        t = cyc;
    endtask
    // ---------------------------------------------------------------
    // watchdog: about twice the ~30k cycles the sequence needs
    // ---------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge mclk_i);
        err_count++;
        final_report();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin : main
        logic [31:0] d, v, v2;
        logic [1:0]  r;
        int          t1, t2, w;
        int          thr_bits [3];
        err_count = 0;
        n_compared = 0;
        rstn_i <= 1'b0;
        ev <= hsief_irq_t'(6'h00);
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0000_0000;
        wstrb <= 4'h0;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b0;
        thr_bits = '{5, 1, 0};
        repeat (5) @(posedge mclk_i);
        rstn_i <= 1'b1;
        // reset state of outputs and registers
        irq_chk(1, 1'b0);
        check(32'(sof), 32'h0000_0000);
        rd_chk(`HSIEF_FRI_OFS, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(`HSIEF_EN_OFS, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(`HSIEF_STS_OFS, 32'h0000_103f, 32'h0000_1000);
        // reserved enable bits stay zero
        wr(`HSIEF_EN_OFS, 32'hffff_ffff);
        rd_chk(`HSIEF_EN_OFS, 32'hffff_ffff, 32'h0000_003f);
        // unmapped offsets answer with slave error
        axi_rd(8'h40, d, r);
        check(32'(r), 32'(HSIEF_SLVERR));
        check(d, 32'h0000_0000);
        axi_wr(8'h44, 32'h0000_0001, 4'hf, r);
        check(32'(r), 32'(HSIEF_SLVERR));
        // halted: immediate pairs fire at once, threshold pairs wait
        for (int k = 0; k < 6; k++) begin
            pulse(k);
            irq_chk(2, (k >= 2 && k <= 4));
            rd_chk(`HSIEF_STS_OFS, 32'h1 << k, 32'h1 << k);
            wr(`HSIEF_STS_OFS, 32'h1 << k);
            irq_chk(2, 1'b0);
        end
        // masked flag holds until its enable is set
        wr(`HSIEF_EN_OFS, 32'h0000_0000);
        pulse(4);
        irq_chk(3, 1'b0);
        wr(`HSIEF_EN_OFS, 32'h0000_0010);
        irq_chk(2, 1'b1);
        wr(`HSIEF_STS_OFS, 32'h0000_0010);
        irq_chk(2, 1'b0);
        // frame index write while halted, every list size
        wr(`HSIEF_FRI_OFS, 32'h0000_3abd);
        rd_chk(`HSIEF_FRI_OFS, 32'hffff_ffff, 32'h0000_3abd);
        check(32'(sof), 32'h0000_3abd >> 3);
        for (int f = 0; f < 3; f++) begin
            wr(`HSIEF_CMD_OFS, 32'(f) << 2);
            check(32'(entry), (32'h0000_3abd & ((32'h1 << (13 - f)) - 1)) >> 3);
        end
        // run from the top value: wrap to zero raises rollover
        wr(`HSIEF_FRI_OFS, 32'h0000_3fff);
        wr(`HSIEF_EN_OFS, 32'h0000_0008);
        wr(`HSIEF_CMD_OFS, 32'h0001_0001);
        check(32'(run), 32'h0000_0001);
        sync(v, t1);
        check(v, 32'h0000_0000);
        check(32'(sof), 32'h0000_0000);
        irq_chk(0, 1'b1);
        rd_chk(`HSIEF_STS_OFS, 32'h0000_0008, 32'h0000_0008);
        wr(`HSIEF_STS_OFS, 32'h0000_0008);
        irq_chk(2, 1'b0);
        // one step per microframe
        sync(v, t1);
        sync(v2, t2);
        check(v2, v + 1);
        check(32'((t2 - t1) >= 3118 && (t2 - t1) <= 3132), 32'h0000_0001);
        // threshold pairs wait for the next boundary, one microframe away
        for (int i = 0; i < 3; i++) begin
            wr(`HSIEF_EN_OFS, 32'h1 << thr_bits[i]);
            sync(v, t1);
            pulse(thr_bits[i]);
            irq_chk(4, 1'b0);
            w = 0;
            while (irq !== 1'b1 && w < 3300) begin
                @(negedge mclk_i);
                w++;
            end
            check(32'(w >= 3050 && w < 3300), 32'h0000_0001);
            wr(`HSIEF_STS_OFS, 32'h1 << thr_bits[i]);
            irq_chk(2, 1'b0);
        end
        wr(`HSIEF_CMD_OFS, 32'h0000_0000);
        final_report();
    end
endmodule
`default_nettype wire
